//--- inc/ssx_pkg.sv
// Purpose: shared constants for the swap, skip, table and xor execution block
// Assumes: 8-bit data path, 14-bit program words, 11-bit program address
// Notes: operation codes are issued by the decoder as a 4-bit enum
`default_nettype none
package ssx_pkg;
    localparam int DATA_W = 8;
    localparam int PROG_W = 14;
    localparam int PADDR_W = 11;
    localparam int HIGH_W = PROG_W - DATA_W;
    localparam int NIB_W = 4;
    localparam int BIT_SEL_W = 3;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [5:0] ZERO_HIGH = 6'h00;
    localparam logic [2:0] LAST_PAGE = 3'h7;

    typedef enum logic [3:0] {
        SSX_OP_NONE,
        SSX_OP_NIBSWAP,
        SSX_OP_SKIPZ,
        SSX_OP_COPYSKIP,
        SSX_OP_BITSKIP,
        SSX_OP_TABCUR,
        SSX_OP_TABLAST,
        SSX_OP_XORA,
        SSX_OP_XORMEM,
        SSX_OP_XORI
    } ssx_op_t;

    typedef enum {
        SSX_ST_RUN,
        SSX_ST_TABLE,
        SSX_ST_DUMMY
    } ssx_state_t;
endpackage : ssx_pkg
`default_nettype wire

//--- rtl/ssx_exec.sv
// Purpose: execution tail of an 8-bit core: swap, skips, table reads, xor
// Assumes: nothing of opValid while busy is high; an op offered outside the run state is ignored
// Notes: memory and accumulator writes are one-cycle strobes from flops
//
// Behaviour
// - swap to accumulator: acc low gets mem high, acc high gets mem low
// - byte zero test: zero byte drops prefetch, dummy cycle, two cycles total
// - copy and test: byte to accumulator, zero drops prefetch with dummy cycle
// - bit test: selected bit clear drops prefetch with dummy cycle
// - current page table read: low byte to memory, high part to latch
// - final page table read: low byte to memory, high part to latch
// - xor with memory into accumulator, updates zero flag only
// - xor into memory, updates zero flag only
// - xor with immediate into accumulator, updates zero flag only
`default_nettype none
module ssx_exec #(
    parameter int PAGE_W = 3
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic opValid,
    input wire ssx_pkg::ssx_op_t opCode,
    input wire logic [7:0] memData,
    input wire logic [7:0] accData,
    input wire logic [7:0] immData,
    input wire logic [2:0] bitSel,
    input wire logic [7:0] tablePointer,
    input wire logic [10:0] progCounter,
    input wire logic [13:0] romData,
    output logic accWrite,
    output logic [7:0] accOut,
    output logic memWrite,
    output logic [7:0] memOut,
    output logic zeroWrite,
    output logic zeroOut,
    output logic [5:0] tableHighLatch,
    output logic romRead,
    output logic [10:0] romAddr,
    output logic flushPrefetch,
    output logic busy
);
    // refuse a page width that does not fill the program address
    if (PAGE_W + ssx_pkg::DATA_W != ssx_pkg::PADDR_W)
    begin : gPageCheck
        $error("page width does not fit program address");
    end

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    function automatic logic isZero(input logic [7:0] v);
        isZero = (v == ssx_pkg::ZERO_BYTE);
    endfunction : isZero

    ssx_pkg::ssx_state_t state_q, state_d;
    wire logic take = opValid && (state_q == ssx_pkg::SSX_ST_RUN);
    wire logic [7:0] swapped = {memData[3:0], memData[7:4]};
    wire logic [7:0] xorMem = accData ^ memData;
    wire logic [7:0] xorImm = accData ^ immData;
    wire logic isTable = (opCode == ssx_pkg::SSX_OP_TABCUR)
        || (opCode == ssx_pkg::SSX_OP_TABLAST);
    wire logic [2:0] pageSel = (opCode == ssx_pkg::SSX_OP_TABLAST)
        ? ssx_pkg::LAST_PAGE : progCounter[10:8];
    wire logic skipHit =
        ((opCode == ssx_pkg::SSX_OP_SKIPZ) && isZero(memData))
        || ((opCode == ssx_pkg::SSX_OP_COPYSKIP) && isZero(memData))
        || ((opCode == ssx_pkg::SSX_OP_BITSKIP) && !memData[bitSel]);

    // result selection for accumulator, memory and zero flag; skips other than copy write nothing
    logic accW;
    logic [7:0] accV;
    logic memW;
    logic [7:0] memV;
    logic zW;
    logic [7:0] zSrc;
    always_comb
    begin
        accW = 1'b0;
        accV = ssx_pkg::ZERO_BYTE;
        memW = 1'b0;
        memV = ssx_pkg::ZERO_BYTE;
        zW = 1'b0;
        zSrc = ssx_pkg::ZERO_BYTE;
        if (take)
        begin
            case (opCode)
                ssx_pkg::SSX_OP_NIBSWAP:
                begin
                    accW = 1'b1;
                    accV = swapped;
                end
                ssx_pkg::SSX_OP_COPYSKIP:
                begin
                    accW = 1'b1;
                    accV = memData;
                end
                ssx_pkg::SSX_OP_XORA:
                begin
                    accW = 1'b1;
                    accV = xorMem;
                    zW = 1'b1;
                    zSrc = xorMem;
                end
                ssx_pkg::SSX_OP_XORMEM:
                begin
                    memW = 1'b1;
                    memV = xorMem;
                    zW = 1'b1;
                    zSrc = xorMem;
                end
                ssx_pkg::SSX_OP_XORI:
                begin
                    accW = 1'b1;
                    accV = xorImm;
                    zW = 1'b1;
                    zSrc = xorImm;
                end
                default:
                begin
                    accW = 1'b0;
                end
            endcase
        end
        else if (state_q == ssx_pkg::SSX_ST_TABLE)
        begin
            memW = 1'b1;
            memV = romData[7:0];
        end
    end

    // ----------------------------------------------------------------
    // sequencer: table read waits one cycle for rom, skip adds dummy
    // ----------------------------------------------------------------
    always_comb
    begin
        state_d = ssx_pkg::SSX_ST_RUN;
        case (state_q)
            ssx_pkg::SSX_ST_RUN:
            begin
                if (take && isTable)
                begin
                    state_d = ssx_pkg::SSX_ST_TABLE;
                end
                else if (take && skipHit)
                begin
                    state_d = ssx_pkg::SSX_ST_DUMMY;
                end
            end
            default:
            begin
                state_d = ssx_pkg::SSX_ST_RUN;
            end
        endcase
    end

    // registered outputs
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            state_q <= ssx_pkg::SSX_ST_RUN;
            accWrite <= 1'b0;
            accOut <= ssx_pkg::ZERO_BYTE;
            memWrite <= 1'b0;
            memOut <= ssx_pkg::ZERO_BYTE;
            zeroWrite <= 1'b0;
            zeroOut <= 1'b0;
            tableHighLatch <= ssx_pkg::ZERO_HIGH;
            romRead <= 1'b0;
            romAddr <= 11'h000;
            flushPrefetch <= 1'b0;
            busy <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            accWrite <= accW;
            accOut <= accV;
            memWrite <= memW;
            memOut <= memV;
            zeroWrite <= zW;
            zeroOut <= isZero(zSrc);
            if (state_q == ssx_pkg::SSX_ST_TABLE)
            begin
                tableHighLatch <= romData[13:8];
            end
            romRead <= take && isTable;
            romAddr <= (take && isTable) ? {pageSel, tablePointer} : romAddr;
            flushPrefetch <= take && skipHit && !isTable;
            busy <= (state_d != ssx_pkg::SSX_ST_RUN);
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    swap_nibble_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        take && opCode == ssx_pkg::SSX_OP_NIBSWAP |=> accWrite && !memWrite
        && accOut == {$past(memData[3:0]), $past(memData[7:4])})
        else $error("swap result wrong");
    skip_byte_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        take && opCode == ssx_pkg::SSX_OP_SKIPZ |=>
        flushPrefetch == ($past(memData) == 8'h00) && !accWrite && !memWrite)
        else $error("byte skip wrong");
    copy_skip_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        take && opCode == ssx_pkg::SSX_OP_COPYSKIP |=> accOut == $past(memData)
        && accWrite && flushPrefetch == ($past(memData) == 8'h00))
        else $error("copy skip wrong");
    bit_skip_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        take && opCode == ssx_pkg::SSX_OP_BITSKIP && !memData[bitSel]
        |=> flushPrefetch && busy ##1 !busy)
        else $error("bit skip wrong");
    table_cur_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        take && opCode == ssx_pkg::SSX_OP_TABCUR |=> romRead
        && romAddr == {$past(progCounter[10:8]), $past(tablePointer)}
        ##1 memWrite && memOut == $past(romData[7:0]) && tableHighLatch == $past(romData[13:8]))
        else $error("current page table read wrong");
    table_last_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        take && opCode == ssx_pkg::SSX_OP_TABLAST |=> romRead
        && romAddr == {3'h7, $past(tablePointer)} ##1 memWrite && !zeroWrite)
        else $error("final page table read wrong");
    xor_acc_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        take && opCode == ssx_pkg::SSX_OP_XORA |=> accWrite && zeroWrite
        && accOut == ($past(accData) ^ $past(memData)))
        else $error("xor to acc wrong");
    xor_mem_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        take && opCode == ssx_pkg::SSX_OP_XORMEM |=> memWrite && !accWrite
        && memOut == ($past(accData) ^ $past(memData)))
        else $error("xor to memory wrong");
    xor_imm_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        take && opCode == ssx_pkg::SSX_OP_XORI |=> accWrite
        && accOut == ($past(accData) ^ $past(immData)))
        else $error("xor immediate wrong");
    zero_flag_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        zeroWrite |-> zeroOut == ((accWrite ? accOut : memOut) == 8'h00))
        else $error("zero flag wrong");
    single_cycle_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        take && !isTable && !skipHit |=> !busy)
        else $error("non-skip took extra cycle");
endmodule : ssx_exec
`default_nettype wire

//--- dv/testbench.sv
// Purpose: self-checking bench for the swap, skip, table and xor block
// Assumes: one busy cycle after a skip hit or a table read
// Notes: expected results are queued per kind and taken off by a monitor
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic opValid = 1'b0;
    ssx_pkg::ssx_op_t opCode = ssx_pkg::SSX_OP_NONE;
    logic [7:0] memData = 8'h00, accData = 8'h00, immData = 8'h00, tablePointer = 8'h00;
    logic [2:0] bitSel = 3'h0;
    logic [10:0] progCounter = 11'h000;
    logic [13:0] romData, romWord;
    logic accWrite, memWrite, zeroWrite, zeroOut, romRead, flushPrefetch, busy;
    logic [7:0] accOut, memOut;
    logic [5:0] tableHighLatch, expHigh = 6'h00;
    logic [10:0] romAddr;
    logic [13:0] expQ [5][$]; // 0 acc, 1 mem, 2 zero, 3 flush, 4 rom address
    int fail_count = 0, num_checks = 0;
    // -------------------------------------------------------------
    // clock, rom and device
    // -------------------------------------------------------------
    initial forever #2.5 clk_sys = ~clk_sys;
    function automatic logic [13:0] romFn(logic [10:0] a);
        return {a[10:5], a[7:0] ^ 8'h5a};
    endfunction : romFn
    // rom answers only while read; otherwise the inverted word
    assign romWord = romFn(romAddr);
    assign romData = romRead ? romWord : ~romWord;
    ssx_exec #(.PAGE_W(3)) dut (.clk_sys(clk_sys), .nrst(nrst), .opValid(opValid),
        .opCode(opCode), .memData(memData), .accData(accData), .immData(immData),
        .bitSel(bitSel), .tablePointer(tablePointer), .progCounter(progCounter),
        .romData(romData), .accWrite(accWrite), .accOut(accOut), .memWrite(memWrite),
        .memOut(memOut), .zeroWrite(zeroWrite), .zeroOut(zeroOut),
        .tableHighLatch(tableHighLatch), .romRead(romRead), .romAddr(romAddr),
        .flushPrefetch(flushPrefetch), .busy(busy));
    // -------------------------------------------------------------
    // checking
    // -------------------------------------------------------------
    task automatic chkVal(logic [13:0] e, logic [13:0] g, string what);
        num_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, g, e);
        end
    endtask : chkVal
    task automatic take(int k, logic [13:0] g, string what);
        if (expQ[k].size() == 0)
            chkVal(~g, g, {what, " unexpected"});
        else
            chkVal(expQ[k].pop_front(), g, what);
    endtask : take
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : complete_run
    // monitor: each strobe takes the oldest note of its kind
    always @(negedge clk_sys)
    begin
        if (nrst === 1'b1)
        begin
            if (accWrite !== 1'b0) take(0, {6'h00, accOut}, "acc");
            if (memWrite !== 1'b0) take(1, {tableHighLatch, memOut}, "mem");
            if (zeroWrite !== 1'b0) take(2, {13'h0, zeroOut}, "zero");
            if (flushPrefetch !== 1'b0) take(3, 14'h1, "flush");
            if (romRead !== 1'b0) take(4, {3'h0, romAddr}, "rom addr");
        end
    end
    // -------------------------------------------------------------
    // stimulus
    // -------------------------------------------------------------
    task automatic issue(int k, logic [7:0] m, logic ref_bad);
        ssx_pkg::ssx_op_t op;
        logic [7:0] a, i, tp;
        logic [2:0] b;
        logic [10:0] pc, ad;
        logic hold;
        op = ssx_pkg::ssx_op_t'(k);
        a = 8'($urandom);
        i = 8'($urandom);
        tp = 8'($urandom);
        b = 3'($urandom);
        pc = 11'($urandom);
        hold = 1'b0;
        @(posedge clk_sys);
        opValid <= 1'b1;
        opCode <= op;
        memData <= m;
        accData <= a;
        immData <= i;
        bitSel <= b;
        tablePointer <= tp;
        progCounter <= pc;
        case (op)
            ssx_pkg::SSX_OP_NIBSWAP: expQ[0].push_back({6'h00, m[3:0], m[7:4]});
            ssx_pkg::SSX_OP_SKIPZ: hold = (m == 8'h00);
            ssx_pkg::SSX_OP_COPYSKIP:
            begin
                expQ[0].push_back({6'h00, m});
                hold = (m == 8'h00);
            end
            ssx_pkg::SSX_OP_BITSKIP: hold = ~m[b];
            ssx_pkg::SSX_OP_TABCUR, ssx_pkg::SSX_OP_TABLAST:
            begin
                ad = {(op == ssx_pkg::SSX_OP_TABLAST) ? 3'h7 : pc[10:8], tp};
                expHigh = 6'(romFn(ad) >> 8);
                expQ[4].push_back({3'h0, ad});
                expQ[1].push_back(romFn(ad));
            end
            ssx_pkg::SSX_OP_XORA: expQ[0].push_back({6'h00, a ^ m});
            ssx_pkg::SSX_OP_XORMEM: expQ[1].push_back({expHigh, a ^ m});
            ssx_pkg::SSX_OP_XORI: expQ[0].push_back({6'h00, a ^ i});
            default: ;
        endcase
        if (op == ssx_pkg::SSX_OP_XORA || op == ssx_pkg::SSX_OP_XORMEM)
            expQ[2].push_back({13'h0, (a ^ m) == 8'h00});
        if (op == ssx_pkg::SSX_OP_XORI)
            expQ[2].push_back({13'h0, (a ^ i) == 8'h00});
        if (hold)
            expQ[3].push_back(14'h1);
        if (hold || op == ssx_pkg::SSX_OP_TABCUR || op == ssx_pkg::SSX_OP_TABLAST)
        begin
            @(posedge clk_sys);
            opValid <= ref_bad; // offered while busy, must be ignored
            opCode <= ssx_pkg::SSX_OP_XORA;
            @(negedge clk_sys);
            chkVal(14'h1, {13'h0, busy}, "busy");
        end
    endtask : issue
    initial
    begin
        #20000;
        fail_count++;
        complete_run();
    end
    initial
    begin
        void'($urandom(67825));
        repeat (6) @(posedge clk_sys);
        chkVal(14'h0, {accWrite, memWrite, zeroWrite, flushPrefetch, romRead, busy}, "reset");
        nrst <= 1'b1;
        for (int k = 0; k < 10; k++)
        begin
            issue(k, 8'h00, 1'b1);
            issue(k, 8'hff, 1'b0);
        end
        for (int n = 0; n < 400; n++)
            issue($urandom % 10, ($urandom % 4 == 0) ? 8'h00 : 8'($urandom), 1'($urandom));
        @(posedge clk_sys);
        opValid <= 1'b0;
        repeat (4) @(posedge clk_sys);
        for (int k = 0; k < 5; k++)
            chkVal(14'h0, 14'(expQ[k].size()), "missing results");
        complete_run();
    end
endmodule : testbench
`default_nettype wire
